// file: logic/rtc_interrupt_power_mgmt.sv
// Contract
// - Reset leaves shared pin running crystal clock
// - Reset: 24h, offset zero, timers, enables off
// - Reset: switch-over, battery-low off, small capacitor
// - Both interrupts active low; primary shares clock pin
// - Primary combines eight event sources
// - Secondary driven only by timer B
// - One bit selects pulse for second, timer A
// - Separate bit selects pulse for timer B
// - Other sources except offset pulse give level following flag
// - Five flags clearable by host write
// - Watchdog flag read-only, cleared by control 2 read
// - Low codes select standard, direct, off with detection
// - Upper codes mirror without detection; 110 forbidden
// - Code 111 plus main loss gives standby
// - Battery switch sets flag, then gated interrupt
// - Flag cleared only on main; interrupt holds
// - On battery ignore interface, outputs high impedance
// - Switch-over disabled reads flag as zero
// - Direct: main below battery; standard: also threshold
// - Battery-low enable makes primary follow flag
// - Battery-low flag read-only, hardware cleared, monitored only in low codes
// - Battery-low interrupt holds until flag or enable clear
// - Control 3 field and bit layout
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module rtc_interrupt_power_mgmt
    import pwr_irq_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // Register port
    input wire logic [4:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rdata_oe_out,
    // Event sources and crystal clock enable
    input wire events_s events_in,
    input wire logic xtal_tick_in,
    // Comparators, asynchronous
    input wire compare_s compare_in,
    // Interrupt pins, open drain except primary, which drives high while in reset
    output logic primary_irq_n_out,
    output logic primary_irq_oe_out,
    output logic timer_b_irq_n_out,
    output logic timer_b_irq_oe_out,
    // Status to analog and datapath
    output logic on_battery_out,
    output logic cap_sel_out,
    output logic hour12_out,
    output logic [7:0] offset_out
);

    // Reset release synchroniser
    logic rst_meta_ff, rst_sync_ff;
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    wire logic rst_n = rst_sync_ff;

    // Comparator synchronisers; first stage read only by the second
    compare_s cmp_meta_ff, cmp_ff;
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            cmp_meta_ff <= '0;
            cmp_ff <= '0;
        end else begin
            cmp_meta_ff <= compare_in;
            cmp_ff <= cmp_meta_ff;
        end
    end

    function automatic logic swo_enabled(input logic [2:0] pm);
        // Codes 010, 110 and 111 leave switch-over off
        swo_enabled = (pm != PM_OFF_BLD) && (pm != PM_NOT_ALLOWED) && (pm != PM_OFF);
    endfunction

    function automatic logic blo_enabled(input logic [2:0] pm);
        blo_enabled = !pm[2];
    endfunction

    // Registers
    logic [7:0] ctrl1_ff, nxt_ctrl1;
    logic [7:0] ctrl2_ff, nxt_ctrl2;
    logic [2:0] pm_ff, nxt_pm;
    logic swo_flag_ff, nxt_swo_flag;
    logic blo_flag_ff, nxt_blo_flag;
    logic swo_ie_ff, nxt_swo_ie;
    logic blo_ie_ff, nxt_blo_ie;
    logic [7:0] offset_ff, nxt_offset;
    logic [7:0] tmr_clock_output_ff, nxt_tmr_clock_output;
    supply_e supply_ff, nxt_supply;
    logic soft_rst;
    logic main_fail;
    logic bus_ok;
    logic wr_ok;
    logic rd_ok;

    always_comb begin
        case (pm_ff)
            PM_STD_BLD, PM_STD:
                main_fail = cmp_ff.main_below_bat && cmp_ff.main_below_switch_threshold;
            PM_DIRECT_BLD, PM_DIRECT: main_fail = cmp_ff.main_below_bat;
            default: main_fail = cmp_ff.main_below_bat;
        endcase
        bus_ok = (supply_ff == SUP_MAIN);
        wr_ok = reg_wr_in && bus_ok;
        rd_ok = reg_rd_in && bus_ok;
        soft_rst = wr_ok && (reg_addr_in == ADDR_CTRL1) && (reg_wdata_in == SOFT_RESET_CODE);
    end

    // Supply state machine
    always_comb begin
        nxt_supply = supply_ff;
        case (supply_ff)
            SUP_MAIN: begin
                if (main_fail) begin
                    nxt_supply = swo_enabled(pm_ff) ? SUP_BATTERY : SUP_STANDBY;
                end
            end
            SUP_BATTERY: if (!main_fail) nxt_supply = SUP_MAIN;
            SUP_STANDBY: if (!cmp_ff.main_below_bat) nxt_supply = SUP_MAIN;
            default: nxt_supply = SUP_MAIN;
        endcase
    end

    // Register next values
    always_comb begin
        nxt_ctrl1 = ctrl1_ff;
        nxt_ctrl2 = ctrl2_ff;
        nxt_pm = pm_ff;
        nxt_swo_flag = swo_flag_ff;
        nxt_blo_flag = blo_flag_ff;
        nxt_swo_ie = swo_ie_ff;
        nxt_blo_ie = blo_ie_ff;
        nxt_offset = offset_ff;
        nxt_tmr_clock_output = tmr_clock_output_ff;
        if (soft_rst) begin
            nxt_ctrl1 = CTRL1_RST;
            nxt_ctrl2 = CTRL2_RST;
            nxt_pm = PM_RST;
            nxt_swo_flag = 1'b0;
            nxt_swo_ie = 1'b0;
            nxt_blo_ie = 1'b0;
            nxt_offset = OFFSET_RST;
            nxt_tmr_clock_output = TMR_CLOCK_OUTPUT_RST;
        end else if (wr_ok) begin
            case (reg_addr_in)
                ADDR_CTRL1: nxt_ctrl1 = reg_wdata_in;
                ADDR_CTRL2: begin
                    // flags clear on a written zero; watchdog flag ignores writes
                    nxt_ctrl2[CTA_FLAG_BIT] = ctrl2_ff[CTA_FLAG_BIT] & reg_wdata_in[CTA_FLAG_BIT];
                    nxt_ctrl2[CTB_FLAG_BIT] = ctrl2_ff[CTB_FLAG_BIT] & reg_wdata_in[CTB_FLAG_BIT];
                    nxt_ctrl2[SEC_FLAG_BIT] = ctrl2_ff[SEC_FLAG_BIT] & reg_wdata_in[SEC_FLAG_BIT];
                    nxt_ctrl2[ALM_FLAG_BIT] = ctrl2_ff[ALM_FLAG_BIT] & reg_wdata_in[ALM_FLAG_BIT];
                    nxt_ctrl2[WDG_IE_BIT] = reg_wdata_in[WDG_IE_BIT];
                    nxt_ctrl2[CTA_IE_BIT] = reg_wdata_in[CTA_IE_BIT];
                    nxt_ctrl2[CTB_IE_BIT] = reg_wdata_in[CTB_IE_BIT];
                end
                ADDR_CTRL3: begin
                    if (reg_wdata_in[PM_HI:PM_LO] != PM_NOT_ALLOWED) begin
                        nxt_pm = reg_wdata_in[PM_HI:PM_LO];
                    end
                    // write of zero only honoured on main supply
                    nxt_swo_flag = swo_flag_ff & reg_wdata_in[SWO_FLAG_BIT];
                    nxt_swo_ie = reg_wdata_in[SWO_IE_BIT];
                    nxt_blo_ie = reg_wdata_in[BLO_IE_BIT];
                end
                ADDR_OFFSET: nxt_offset = reg_wdata_in;
                ADDR_TMR_CLOCK_OUTPUT: nxt_tmr_clock_output = reg_wdata_in;
                default: ;
            endcase
        end
        // read of control 2 clears watchdog flag
        if (rd_ok && (reg_addr_in == ADDR_CTRL2)) begin
            nxt_ctrl2[WDG_FLAG_BIT] = 1'b0;
        end
        // Hardware set wins over a clear in the same cycle
        if (events_in.watchdog_a) nxt_ctrl2[WDG_FLAG_BIT] = 1'b1;
        if (events_in.timer_a) nxt_ctrl2[CTA_FLAG_BIT] = 1'b1;
        if (events_in.timer_b) nxt_ctrl2[CTB_FLAG_BIT] = 1'b1;
        if (events_in.second_tick) nxt_ctrl2[SEC_FLAG_BIT] = 1'b1;
        if (events_in.alarm) nxt_ctrl2[ALM_FLAG_BIT] = 1'b1;
        if (supply_ff == SUP_MAIN && nxt_supply == SUP_BATTERY) begin
            nxt_swo_flag = 1'b1;
        end
        if (!swo_enabled(nxt_pm)) nxt_swo_flag = 1'b0;
        // set by the detector only, cleared by it or by an upper power mode code, also on battery
        if (blo_enabled(pm_ff)) begin
            nxt_blo_flag = cmp_ff.bat_below_battery_low_threshold;
        end else begin
            nxt_blo_flag = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl1_ff <= CTRL1_RST;
            ctrl2_ff <= CTRL2_RST;
            pm_ff <= PM_RST;
            swo_flag_ff <= 1'b0;
            blo_flag_ff <= 1'b0;
            swo_ie_ff <= 1'b0;
            blo_ie_ff <= 1'b0;
            offset_ff <= OFFSET_RST;
            tmr_clock_output_ff <= TMR_CLOCK_OUTPUT_RST;
            supply_ff <= SUP_MAIN;
        end else begin
            ctrl1_ff <= nxt_ctrl1;
            ctrl2_ff <= nxt_ctrl2;
            pm_ff <= nxt_pm;
            swo_flag_ff <= nxt_swo_flag;
            blo_flag_ff <= nxt_blo_flag;
            swo_ie_ff <= nxt_swo_ie;
            blo_ie_ff <= nxt_blo_ie;
            offset_ff <= nxt_offset;
            tmr_clock_output_ff <= nxt_tmr_clock_output;
            supply_ff <= nxt_supply;
        end
    end

    // Interrupt combining
    logic pulse_a_sel, pulse_b_sel;
    logic prim_active, timer_b_active;
    logic [7:0] nxt_rdata;
    logic nxt_rdata_oe;
    logic clk_phase_ff, nxt_clk_phase;
    logic nxt_prim_n, nxt_tb_n;

    always_comb begin
        pulse_a_sel = tmr_clock_output_ff[TA_PULSE_BIT];
        pulse_b_sel = tmr_clock_output_ff[TB_PULSE_BIT];
        prim_active =
            (ctrl1_ff[SEC_IE_BIT] &&
                (pulse_a_sel ? events_in.second_tick : ctrl2_ff[SEC_FLAG_BIT])) ||
            (ctrl2_ff[CTA_IE_BIT] &&
                (pulse_a_sel ? events_in.timer_a : ctrl2_ff[CTA_FLAG_BIT])) ||
            (ctrl2_ff[WDG_IE_BIT] && ctrl2_ff[WDG_FLAG_BIT]) ||
            (ctrl2_ff[CTB_IE_BIT] &&
                (pulse_b_sel ? events_in.timer_b : ctrl2_ff[CTB_FLAG_BIT])) ||
            (ctrl1_ff[ALARM_IE_BIT] && ctrl2_ff[ALM_FLAG_BIT]) ||
            (swo_ie_ff && swo_flag_ff) ||
            (blo_ie_ff && blo_flag_ff) ||
            events_in.offset_pulse;
        timer_b_active = ctrl2_ff[CTB_IE_BIT] &&
            (pulse_b_sel ? events_in.timer_b : ctrl2_ff[CTB_FLAG_BIT]);
        nxt_clk_phase = xtal_tick_in ? !clk_phase_ff : clk_phase_ff;
        // clock output when enabled, else active-low interrupt
        if (!tmr_clock_output_ff[CLOCK_OUTPUT_DIS_BIT]) begin
            nxt_prim_n = nxt_clk_phase;
        end else begin
            nxt_prim_n = !prim_active;
        end
        nxt_tb_n = !timer_b_active;
        nxt_rdata = DATA_ZERO;
        nxt_rdata_oe = 1'b0;
        if (rd_ok) begin
            nxt_rdata_oe = 1'b1;
            case (reg_addr_in)
                ADDR_CTRL1: nxt_rdata = ctrl1_ff;
                ADDR_CTRL2: nxt_rdata = ctrl2_ff;
                ADDR_CTRL3: begin
                    nxt_rdata[PM_HI:PM_LO] = pm_ff;
                    nxt_rdata[SWO_FLAG_BIT] = swo_flag_ff;
                    nxt_rdata[BLO_FLAG_BIT] = blo_flag_ff;
                    nxt_rdata[SWO_IE_BIT] = swo_ie_ff;
                    nxt_rdata[BLO_IE_BIT] = blo_ie_ff;
                end
                ADDR_OFFSET: nxt_rdata = offset_ff;
                ADDR_TMR_CLOCK_OUTPUT: nxt_rdata = tmr_clock_output_ff;
                default: nxt_rdata = DATA_ZERO;
            endcase
        end
    end

    logic prim_n_ff, tb_n_ff;
    logic [7:0] rdata_ff;
    logic rdata_oe_ff;
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            clk_phase_ff <= 1'b0;
            prim_n_ff <= 1'b1;
            tb_n_ff <= 1'b1;
            rdata_ff <= DATA_ZERO;
            rdata_oe_ff <= 1'b0;
        end else begin
            clk_phase_ff <= nxt_clk_phase;
            prim_n_ff <= nxt_prim_n;
            tb_n_ff <= nxt_tb_n;
            rdata_ff <= nxt_rdata;
            rdata_oe_ff <= nxt_rdata_oe;
        end
    end

    logic prim_oe_ff, tb_oe_ff;
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            prim_oe_ff <= 1'b1;
            tb_oe_ff <= 1'b0;
        end else begin
            prim_oe_ff <= !nxt_prim_n;
            tb_oe_ff <= !nxt_tb_n;
        end
    end

    logic on_bat_ff;
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            on_bat_ff <= 1'b0;
        end else begin
            on_bat_ff <= (nxt_supply != SUP_MAIN);
        end
    end

    assign reg_rdata_out = rdata_ff;
    assign reg_rdata_oe_out = rdata_oe_ff;
    assign primary_irq_n_out = prim_n_ff;
    assign primary_irq_oe_out = prim_oe_ff;
    assign timer_b_irq_n_out = tb_n_ff;
    assign timer_b_irq_oe_out = tb_oe_ff;
    assign on_battery_out = on_bat_ff;
    assign cap_sel_out = ctrl1_ff[CAP_SEL_BIT];
    assign hour12_out = ctrl1_ff[HOUR12_BIT];
    assign offset_out = offset_ff;

    // Checks
    a_wdg_read_clear: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        rd_ok && reg_addr_in == ADDR_CTRL2 && !events_in.watchdog_a
        |=> !ctrl2_ff[WDG_FLAG_BIT]) else $error("watchdog flag not cleared by read");
    a_swo_flag_set: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        supply_ff == SUP_MAIN && main_fail && swo_enabled(pm_ff) |=> swo_flag_ff)
        else $error("switch-over flag not set");
    a_swo_zero_off: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        !swo_enabled(pm_ff) |-> !swo_flag_ff) else $error("switch-over flag set while off");
    a_bus_ignored: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        supply_ff != SUP_MAIN && reg_rd_in |=> !reg_rdata_oe_out)
        else $error("interface answered on battery");
    a_standby_entry: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        supply_ff == SUP_MAIN && main_fail && pm_ff == PM_OFF |=> supply_ff == SUP_STANDBY)
        else $error("standby not entered");
    a_tb_irq_only: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        !ctrl2_ff[CTB_IE_BIT] |=> timer_b_irq_n_out) else $error("secondary irq without timer b");
    a_blo_irq: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        tmr_clock_output_ff[CLOCK_OUTPUT_DIS_BIT] && blo_ie_ff && blo_flag_ff |=> !primary_irq_n_out)
        else $error("battery-low irq missing");
    a_blo_write_ignored: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        blo_enabled(pm_ff) && $stable(pm_ff) && cmp_ff.bat_below_battery_low_threshold
        |=> blo_flag_ff) else $error("battery-low flag lost");
    a_pm_never_110: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        pm_ff != PM_NOT_ALLOWED) else $error("forbidden power mode");
    c_to_battery: cover property (@(posedge core_clk_in) disable iff (!rst_n)
        supply_ff == SUP_MAIN ##1 supply_ff == SUP_BATTERY);
    c_standby: cover property (@(posedge core_clk_in) disable iff (!rst_n)
        supply_ff == SUP_STANDBY);
    c_wdg_clear: cover property (@(posedge core_clk_in) disable iff (!rst_n)
        ctrl2_ff[WDG_FLAG_BIT] ##1 !ctrl2_ff[WDG_FLAG_BIT]);

endmodule
`default_nettype wire

// file: logic/pwr_irq_pkg.sv
package pwr_irq_pkg;

    // Register map, byte addressed over the plain register port
    localparam logic [4:0] ADDR_CTRL1 = 5'h00;
    localparam logic [4:0] ADDR_CTRL2 = 5'h01;
    localparam logic [4:0] ADDR_CTRL3 = 5'h02;
    localparam logic [4:0] ADDR_OFFSET = 5'h0E;
    localparam logic [4:0] ADDR_TMR_CLOCK_OUTPUT = 5'h0F;

    // Control 1 fields
    localparam int HOUR12_BIT = 3;
    localparam int SEC_IE_BIT = 2;
    localparam int ALARM_IE_BIT = 1;
    localparam int CAP_SEL_BIT = 7;
    localparam logic [7:0] SOFT_RESET_CODE = 8'h58;

    // Control 2 fields
    localparam int WDG_FLAG_BIT = 7;
    localparam int CTA_FLAG_BIT = 6;
    localparam int CTB_FLAG_BIT = 5;
    localparam int SEC_FLAG_BIT = 4;
    localparam int ALM_FLAG_BIT = 3;
    localparam int WDG_IE_BIT = 2;
    localparam int CTA_IE_BIT = 1;
    localparam int CTB_IE_BIT = 0;

    // Control 3 fields
    localparam int PM_HI = 7;
    localparam int PM_LO = 5;
    localparam int SWO_FLAG_BIT = 3;
    localparam int BLO_FLAG_BIT = 2;
    localparam int SWO_IE_BIT = 1;
    localparam int BLO_IE_BIT = 0;

    // Timer and clock output control fields
    localparam int TA_PULSE_BIT = 7;
    localparam int TB_PULSE_BIT = 6;
    localparam int CLOCK_OUTPUT_DIS_BIT = 3;

    // Reset values
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [2:0] PM_RST = 3'h7;
    localparam logic [7:0] OFFSET_RST = 8'h00;
    localparam logic [7:0] TMR_CLOCK_OUTPUT_RST = 8'h00;
    localparam logic [7:0] DATA_ZERO = 8'h00;

    // Power mode codes
    localparam logic [2:0] PM_STD_BLD = 3'h0;
    localparam logic [2:0] PM_DIRECT_BLD = 3'h1;
    localparam logic [2:0] PM_OFF_BLD = 3'h2;
    localparam logic [2:0] PM_STD = 3'h4;
    localparam logic [2:0] PM_DIRECT = 3'h5;
    localparam logic [2:0] PM_NOT_ALLOWED = 3'h6;
    localparam logic [2:0] PM_OFF = 3'h7;

    typedef enum logic [2:0] {
        SUP_MAIN = 3'b001,
        SUP_BATTERY = 3'b010,
        SUP_STANDBY = 3'b100
    } supply_e;

    // Event pulses from timers, alarm and offset correction
    typedef struct packed {
        logic second_tick;
        logic timer_a;
        logic timer_b;
        logic watchdog_a;
        logic alarm;
        logic offset_pulse;
    } events_s;

    // Analog comparator results
    typedef struct packed {
        logic main_below_bat;
        logic main_below_switch_threshold;
        logic bat_below_battery_low_threshold;
    } compare_s;

endpackage

// file: tb/host_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
    // Clock
    input wire logic clk_in,
    // Register port
    output logic [4:0] addr_out,
    output logic [7:0] wdata_out,
    output logic wr_out,
    output logic rd_out,
    input wire logic [7:0] rdata_in,
    input wire logic rdata_oe_in
);
    initial begin
        addr_out = 5'h00;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end

    // Idle bus carries inverted junk so stale values never look live
    task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask

    task automatic read_reg(input logic [4:0] a, output logic [7:0] d, output logic oe);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        #1;
        d = rdata_in;
        oe = rdata_oe_in;
    endtask
endmodule
`default_nettype wire

// file: tb/test_rtc_interrupt_power_mgmt.sv
`timescale 1ns/10ps
`default_nettype none
module test_rtc_interrupt_power_mgmt
    import pwr_irq_pkg::*;
;
    localparam events_s src_ev [4] = '{events_s'(6'h20), events_s'(6'h10),
        events_s'(6'h08), events_s'(6'h02)};
    localparam int fbit [4] = '{SEC_FLAG_BIT, CTA_FLAG_BIT, CTB_FLAG_BIT, ALM_FLAG_BIT};
    localparam logic [2:0] sw_codes [4] = '{PM_STD_BLD, PM_DIRECT_BLD, PM_STD, PM_DIRECT};
    logic core_clk_in = 1'b0;
    logic rst_b_in;
    logic [4:0] addr;
    logic [7:0] wdata, rdata, offset, np, nb, d, c, e2;
    logic wr, rd, rdata_oe, pp_n, pp_oe, bp_n, bp_oe, on_bat, cap_sel, hour12, xtal, oe;
    logic [2:0] pm;
    events_s ev;
    compare_s cmp;
    int num_errors = 0;
    int comparisons = 0;
    // Open-drain pins with pull-ups
    wire logic prim = pp_oe ? pp_n : 1'b1;
    wire logic bpin = bp_oe ? bp_n : 1'b1;

    always #12.5 core_clk_in = ~core_clk_in;

    host_bus_model host_u (.clk_in(core_clk_in), .addr_out(addr), .wdata_out(wdata),
        .wr_out(wr), .rd_out(rd), .rdata_in(rdata), .rdata_oe_in(rdata_oe));

    rtc_interrupt_power_mgmt dut_u (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .reg_rdata_oe_out(rdata_oe), .events_in(ev),
        .xtal_tick_in(xtal), .compare_in(cmp), .primary_irq_n_out(pp_n),
        .primary_irq_oe_out(pp_oe), .timer_b_irq_n_out(bp_n), .timer_b_irq_oe_out(bp_oe),
        .on_battery_out(on_bat), .cap_sel_out(cap_sel), .hour12_out(hour12),
        .offset_out(offset));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("Comparisons %0d, errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] v;
        logic v_oe;
        host_u.read_reg(a, v, v_oe);
        check({7'h00, v_oe}, 8'h01);
        check(v, exp);
    endtask

    task automatic pins(input logic p, input logic b);
        check({6'h00, prim, bpin}, {6'h00, p, b});
    endtask

    task automatic fire(input events_s e);
        @(posedge core_clk_in);
        ev <= e;
        @(posedge core_clk_in);
        ev <= '0;
    endtask

    task automatic set_cmp(input compare_s v);
        @(posedge core_clk_in);
        cmp <= v;
    endtask

    // Counts low samples on both pins over five cycles
    task automatic count_low(output logic [7:0] p, output logic [7:0] b);
        p = 8'h00;
        b = 8'h00;
        repeat (5) begin
            #1;
            if (prim !== 1'b1) p = p + 8'h01;
            if (bpin !== 1'b1) b = b + 8'h01;
            @(posedge core_clk_in);
        end
    endtask

    // 0 none, 1 single pulse, 2 held level
    function automatic logic [7:0] ev_class(input int m, input int k, input logic sec);
        if (m == 2 || (sec && k != 2)) return 8'h00;
        if (m == 1 && k < 3) return 8'h01;
        return 8'h02;
    endfunction

    task automatic cls_chk(input logic [7:0] n, input logic [7:0] cls);
        if (cls == 8'h02) check({7'h00, n >= 8'h04}, 8'h01);
        else check(n, cls);
    endtask

    task automatic wait_batt(input logic exp);
        int i;
        for (i = 0; i < 12 && on_bat !== exp; i++) idle(1);
        if (on_bat !== exp) begin
            num_errors++;
            close_out();
        end else check({7'h00, on_bat}, {7'h00, exp});
    endtask

    initial begin
        rst_b_in = 1'b0;
        ev = '0;
        cmp = '0;
        xtal = 1'b0;
        void'($urandom(32'hFCE6));
        repeat (6) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        idle(3);
        rd_chk(ADDR_CTRL1, CTRL1_RST);
        rd_chk(ADDR_CTRL2, CTRL2_RST);
        rd_chk(ADDR_CTRL3, 8'hE0);
        rd_chk(ADDR_OFFSET, OFFSET_RST);
        rd_chk(ADDR_TMR_CLOCK_OUTPUT, TMR_CLOCK_OUTPUT_RST);
        rd_chk(5'h05, DATA_ZERO);
        check({5'h00, on_bat, hour12, cap_sel}, 8'h00);
        check(offset, 8'h00);
        for (int i = 0; i < 4; i++) begin
            d[0] = prim;
            @(posedge core_clk_in);
            xtal <= 1'b1;
            @(posedge core_clk_in);
            xtal <= 1'b0;
            idle(2);
            check({7'h00, prim}, {7'h00, ~d[0]});
        end
        for (int m = 0; m < 3; m++) begin
            host_u.write_reg(ADDR_TMR_CLOCK_OUTPUT, (m == 1) ? 8'hC8 : 8'h08);
            host_u.write_reg(ADDR_CTRL1, (m == 2) ? 8'h00 : 8'h06);
            e2 = (m == 2) ? 8'h00 : 8'h03;
            host_u.write_reg(ADDR_CTRL2, e2);
            for (int k = 0; k < 4; k++) begin
                pins(1'b1, 1'b1);
                fire(src_ev[k]);
                count_low(np, nb);
                cls_chk(np, ev_class(m, k, 1'b0));
                cls_chk(nb, ev_class(m, k, 1'b1));
                rd_chk(ADDR_CTRL2, e2 | (8'h01 << fbit[k]));
                host_u.write_reg(ADDR_CTRL2, e2);
                idle(2);
            end
        end
        host_u.write_reg(ADDR_CTRL2, 8'h04);
        fire(events_s'(6'h04));
        host_u.write_reg(ADDR_CTRL2, 8'h04);
        pins(1'b0, 1'b1);
        rd_chk(ADDR_CTRL2, 8'h84);
        rd_chk(ADDR_CTRL2, 8'h04);
        pins(1'b1, 1'b1);
        host_u.write_reg(ADDR_CTRL2, 8'h00);
        // Offset correction pulse reaches the primary pin with no enable
        fire(events_s'(6'h01));
        count_low(np, nb);
        check(np, 8'h01);
        check(nb, 8'h00);
        for (int i = 0; i < 4; i++) begin
            pm = sw_codes[i];
            host_u.write_reg(ADDR_CTRL3, {pm, 5'h02});
            // Forbidden code sent on purpose to see it refused
            host_u.write_reg(ADDR_CTRL3, {PM_NOT_ALLOWED, 5'h02});
            rd_chk(ADDR_CTRL3, {pm, 5'h02});
            set_cmp(compare_s'(3'h4));
            idle(8);
            check({7'h00, on_bat}, {7'h00, pm[0]});
            set_cmp(compare_s'(3'h6));
            wait_batt(1'b1);
            host_u.read_reg(ADDR_CTRL3, d, oe);
            check({7'h00, oe}, 8'h00);
            host_u.write_reg(ADDR_OFFSET, 8'h55);
            set_cmp(compare_s'(3'h0));
            wait_batt(1'b0);
            rd_chk(ADDR_CTRL3, {pm, 5'h0A});
            pins(1'b0, 1'b1);
            rd_chk(ADDR_OFFSET, 8'h00);
            // Flag cleared only once main supply is back
            host_u.write_reg(ADDR_CTRL3, {pm, 5'h02});
            idle(2);
            pins(1'b1, 1'b1);
        end
        for (int i = 0; i < 2; i++) begin
            pm = (i == 0) ? PM_OFF_BLD : PM_OFF;
            host_u.write_reg(ADDR_CTRL3, {pm, 5'h02});
            set_cmp(compare_s'(3'h6));
            idle(8);
            if (pm == PM_OFF) check({7'h00, on_bat}, 8'h01);
            set_cmp(compare_s'(3'h0));
            wait_batt(1'b0);
            rd_chk(ADDR_CTRL3, {pm, 5'h02});
            pins(1'b1, 1'b1);
        end
        for (int i = 0; i < 2; i++) begin
            pm = (i == 0) ? PM_STD_BLD : PM_STD;
            d = {pm, 2'h0, ~pm[2], 2'h1};
            host_u.write_reg(ADDR_CTRL3, {pm, 5'h01});
            set_cmp(compare_s'(3'h1));
            idle(8);
            rd_chk(ADDR_CTRL3, d);
            pins(pm[2], 1'b1);
            host_u.write_reg(ADDR_CTRL3, {pm, 5'h01});
            rd_chk(ADDR_CTRL3, d);
            host_u.write_reg(ADDR_CTRL3, {pm, 5'h00});
            idle(2);
            pins(1'b1, 1'b1);
            set_cmp(compare_s'(3'h0));
            idle(8);
            rd_chk(ADDR_CTRL3, {pm, 5'h00});
        end
        for (int i = 0; i < 16; i++) begin
            d = 8'($urandom());
            c = 8'($urandom()) & 8'h88;
            host_u.write_reg(ADDR_OFFSET, d);
            host_u.write_reg(ADDR_CTRL1, c);
            rd_chk(ADDR_OFFSET, d);
            rd_chk(ADDR_CTRL1, c);
            check(offset, d);
            check({6'h00, cap_sel, hour12}, {6'h00, c[CAP_SEL_BIT], c[HOUR12_BIT]});
        end
        host_u.write_reg(ADDR_CTRL1, SOFT_RESET_CODE);
        idle(2);
        rd_chk(ADDR_CTRL1, CTRL1_RST);
        rd_chk(ADDR_CTRL3, 8'hE0);
        rd_chk(ADDR_OFFSET, OFFSET_RST);
        close_out();
    end
endmodule
`default_nettype wire
